// [event_flags_defs.vh]
// constants for the event flag status block
`ifndef EVENT_FLAGS_DEFS_VH
`define EVENT_FLAGS_DEFS_VH
`define EVF_REG_WIDTH        32
`define EVF_RESET_VAL        32'h0000_0000
`define EVF_IMPL_MASK        32'h0005_ffd7
`define EVF_BIT_PHASE_ORDER  18
`define EVF_BIT_INIT_DONE    16
`define EVF_BIT_CUR_XING_LO  13
`define EVF_BIT_MERGED_XING  12
`define EVF_BIT_VOLT_XING_LO 9
`define EVF_BIT_TIMEOUT_LO   6
`define EVF_BIT_FUND_REACT   4
`define EVF_BIT_APPARENT     2
`define EVF_BIT_REACTIVE     1
`define EVF_BIT_ACTIVE       0
`define EVF_IDLE_RESET       12'h000
`endif

// [sticky_bit.v]
// one sticky event flag with write-one-to-clear
`timescale 1ns/10ps
module sticky_bit
(
  // clock and reset
  input  wire clk_i,
  input  wire nrst_i,
  // event and clear
  input  wire set_i,
  input  wire clr_i,
  // flag
  output reg  flag_o
);
  wire nxt_flag;

  // set wins over a clear in the same cycle
  assign nxt_flag = set_i | (flag_o & ~clr_i);

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flag_o <= 1'b0;
    else
      flag_o <= nxt_flag;
  end
endmodule

// [event_flag_status_low.v]
// lower half of the metering event status flag register
// Contract
// - phase order fault sets bit 18
// - init complete after reset sets bit 16
// - init complete after low power exit
// - per phase current crossings bits 15..13
// - merged voltage crossing sets bit 12
// - per phase voltage crossings bits 11..9
// - per phase crossing timeouts bits 8..6
// - fundamental reactive idle change bit 4
// - apparent idle change sets bit 2
// - reactive idle change sets bit 1
// - active idle change sets bit 0
// - per phase idle indicator records phases
`timescale 1ns/10ps
`include "event_flags_defs.vh"
module event_flag_status_low
(
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // register access
  input  wire        wr_en_i,
  input  wire [31:0] wr_data_i,
  output reg  [31:0] status_ff_o,
  output reg  [11:0] per_phase_idle_indicator_o,
  // event detector pulses
  input  wire        phase_order_fault_i,
  input  wire        power_up_done_i,
  input  wire        mode_wake_done_i,
  input  wire [2:0]  current_crossing_i,
  input  wire        merged_voltage_crossing_i,
  input  wire [2:0]  voltage_crossing_i,
  input  wire [2:0]  crossing_timeout_i,
  // idle levels per phase: [2:0] active, [5:3] reactive,
  // [8:6] apparent, [11:9] fundamental reactive
  input  wire [11:0] phase_idle_i
);
  reg  [11:0] idle_prev_ff;
  reg         idle_valid_ff;
  wire [11:0] idle_change;
  wire [31:0] set_vec;
  wire [31:0] clr_vec;
  wire [31:0] flags;
  reg  [11:0] nxt_indicator;

  // first sample after reset gives no edge, avoiding a spurious event
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      idle_prev_ff  <= `EVF_IDLE_RESET;
      idle_valid_ff <= 1'b0;
    end
    else
    begin
      idle_prev_ff  <= phase_idle_i;
      idle_valid_ff <= 1'b1;
    end
  end

  assign idle_change = (phase_idle_i ^ idle_prev_ff) & {12{idle_valid_ff}};

  assign set_vec[31:19] = 13'h0000;
  assign set_vec[`EVF_BIT_PHASE_ORDER] = phase_order_fault_i;
  assign set_vec[17] = 1'b0;
  assign set_vec[`EVF_BIT_INIT_DONE] =
    power_up_done_i | mode_wake_done_i;
  assign set_vec[15:13] = current_crossing_i;
  assign set_vec[`EVF_BIT_MERGED_XING] = merged_voltage_crossing_i;
  assign set_vec[11:9] = voltage_crossing_i;
  assign set_vec[8:6] = crossing_timeout_i;
  assign set_vec[5] = 1'b0;
  assign set_vec[`EVF_BIT_FUND_REACT] = |idle_change[11:9];
  assign set_vec[3] = 1'b0;
  assign set_vec[`EVF_BIT_APPARENT] = |idle_change[8:6];
  assign set_vec[`EVF_BIT_REACTIVE] = |idle_change[5:3];
  assign set_vec[`EVF_BIT_ACTIVE] = |idle_change[2:0];

  // only a written one clears; zeros leave flags alone
  assign clr_vec = {32{wr_en_i}} & wr_data_i;

  // one sticky cell per implemented position; reserved ones tie low
  sticky_bit phase_order_fault_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_PHASE_ORDER]),
    .clr_i  (clr_vec[`EVF_BIT_PHASE_ORDER]),
    .flag_o (flags[`EVF_BIT_PHASE_ORDER])
  );
  sticky_bit init_complete_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_INIT_DONE]),
    .clr_i  (clr_vec[`EVF_BIT_INIT_DONE]),
    .flag_o (flags[`EVF_BIT_INIT_DONE])
  );
  sticky_bit phase_c_current_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_CUR_XING_LO+2]),
    .clr_i  (clr_vec[`EVF_BIT_CUR_XING_LO+2]),
    .flag_o (flags[`EVF_BIT_CUR_XING_LO+2])
  );
  sticky_bit phase_b_current_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_CUR_XING_LO+1]),
    .clr_i  (clr_vec[`EVF_BIT_CUR_XING_LO+1]),
    .flag_o (flags[`EVF_BIT_CUR_XING_LO+1])
  );
  sticky_bit phase_a_current_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_CUR_XING_LO]),
    .clr_i  (clr_vec[`EVF_BIT_CUR_XING_LO]),
    .flag_o (flags[`EVF_BIT_CUR_XING_LO])
  );
  sticky_bit merged_voltage_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_MERGED_XING]),
    .clr_i  (clr_vec[`EVF_BIT_MERGED_XING]),
    .flag_o (flags[`EVF_BIT_MERGED_XING])
  );
  sticky_bit phase_c_voltage_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_VOLT_XING_LO+2]),
    .clr_i  (clr_vec[`EVF_BIT_VOLT_XING_LO+2]),
    .flag_o (flags[`EVF_BIT_VOLT_XING_LO+2])
  );
  sticky_bit phase_b_voltage_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_VOLT_XING_LO+1]),
    .clr_i  (clr_vec[`EVF_BIT_VOLT_XING_LO+1]),
    .flag_o (flags[`EVF_BIT_VOLT_XING_LO+1])
  );
  sticky_bit phase_a_voltage_crossing_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_VOLT_XING_LO]),
    .clr_i  (clr_vec[`EVF_BIT_VOLT_XING_LO]),
    .flag_o (flags[`EVF_BIT_VOLT_XING_LO])
  );
  sticky_bit phase_c_crossing_timeout_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_TIMEOUT_LO+2]),
    .clr_i  (clr_vec[`EVF_BIT_TIMEOUT_LO+2]),
    .flag_o (flags[`EVF_BIT_TIMEOUT_LO+2])
  );
  sticky_bit phase_b_crossing_timeout_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_TIMEOUT_LO+1]),
    .clr_i  (clr_vec[`EVF_BIT_TIMEOUT_LO+1]),
    .flag_o (flags[`EVF_BIT_TIMEOUT_LO+1])
  );
  sticky_bit phase_a_crossing_timeout_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_TIMEOUT_LO]),
    .clr_i  (clr_vec[`EVF_BIT_TIMEOUT_LO]),
    .flag_o (flags[`EVF_BIT_TIMEOUT_LO])
  );
  sticky_bit fund_reactive_idle_change_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_FUND_REACT]),
    .clr_i  (clr_vec[`EVF_BIT_FUND_REACT]),
    .flag_o (flags[`EVF_BIT_FUND_REACT])
  );
  sticky_bit apparent_idle_change_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_APPARENT]),
    .clr_i  (clr_vec[`EVF_BIT_APPARENT]),
    .flag_o (flags[`EVF_BIT_APPARENT])
  );
  sticky_bit reactive_idle_change_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_REACTIVE]),
    .clr_i  (clr_vec[`EVF_BIT_REACTIVE]),
    .flag_o (flags[`EVF_BIT_REACTIVE])
  );
  sticky_bit active_idle_change_flag_u
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .set_i  (set_vec[`EVF_BIT_ACTIVE]),
    .clr_i  (clr_vec[`EVF_BIT_ACTIVE]),
    .flag_o (flags[`EVF_BIT_ACTIVE])
  );

  assign flags[31:19] = 13'h0;
  assign flags[17]    = 1'b0;
  assign flags[5]     = 1'b0;
  assign flags[3]     = 1'b0;

  // phases that changed are accumulated while the summary flag stands;
  // clearing a summary flag clears its phase bits unless a change arrives
  always @*
  begin
    nxt_indicator = per_phase_idle_indicator_o;
    if (clr_vec[`EVF_BIT_ACTIVE])
      nxt_indicator[2:0] = 3'h0;
    if (clr_vec[`EVF_BIT_REACTIVE])
      nxt_indicator[5:3] = 3'h0;
    if (clr_vec[`EVF_BIT_APPARENT])
      nxt_indicator[8:6] = 3'h0;
    if (clr_vec[`EVF_BIT_FUND_REACT])
      nxt_indicator[11:9] = 3'h0;
    nxt_indicator = nxt_indicator | idle_change;
  end

  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_ff_o                <= `EVF_RESET_VAL;
      per_phase_idle_indicator_o <= `EVF_IDLE_RESET;
    end
    else
    begin
      // mirror lags the flags by one cycle so the output is a flop
      status_ff_o                <= flags & `EVF_IMPL_MASK;
      per_phase_idle_indicator_o <= nxt_indicator;
    end
  end
endmodule

// [evf_chk_properties.sv]
// assertions on the event flag register ports
`timescale 1ns/10ps
module evf_chk (
  // watched ports
  input wire        clk_i, nrst_i, wr_en_i, power_up_done_i,
  input wire [31:0] wr_data_i, status_ff_o,
  input wire [11:0] per_phase_idle_indicator_o, phase_idle_i,
  input wire [2:0]  voltage_crossing_i);
  wire [31:0] s = status_ff_o;
  wire [2:0]  p = phase_idle_i[2:0], q = per_phase_idle_indicator_o[2:0];
  wire        v = voltage_crossing_i[0], c = wr_en_i & wr_data_i[9];
  wire        u = power_up_done_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  init_flag_a: assert property (u |-> ##2 s[16]) else $error("init");
  volt_flag_a: assert property (v |-> ##2 s[9]) else $error("volt");
  set_wins_a: assert property (c && v |-> ##2 s[9]) else $error("win");
  w1c_clear_a: assert property (c && !v |-> ##2 !s[9]) else $error("clr");
  flag_hold_a: assert property (s[9] && !$past(c) |=> s[9])
    else $error("hold");
  rsvd_zero_a: assert property ((s & 32'hfffa_0028) == 32'h0)
    else $error("reserved");
  idle_flag_a: assert property ($changed(p) && $past(nrst_i) |-> ##2 s[0])
    else $error("idle");
  idle_rec_a: assert property ($changed(p) && $past(nrst_i) |=> q != 3'h0)
    else $error("rec");
  cover property (s[16]);
  cover property (c && v);
  cover property (q != 3'h0);
endmodule
bind event_flag_status_low evf_chk chk_u (.*);

// [host_model.sv]
// host model: clears flags once the device has reported ready
`timescale 1ns/10ps
module host_model (
  // host side
  input  wire        clk_i, req_i,
  input  wire [31:0] d_i, st_i,
  output reg         we_o = 1'b0,
  output reg  [31:0] wd_o = 32'h0);
  reg rdy_ff = 1'b0;
  always @(posedge clk_i)
  begin
    rdy_ff <= rdy_ff | st_i[16];
    we_o <= req_i & (rdy_ff | st_i[16]);
    // idle data toggles so a stale word never looks valid
    wd_o <= req_i ? d_i : ~wd_o;
  end
endmodule

// [event_flag_status_low_tb.sv]
// self-checking bench of the event flag status register
`timescale 1ns/10ps
`define CHK(n, e, s) tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, s); end
module event_flag_status_low_tb;
  reg         clk_i = 0, nrst_i = 0, req = 0;
  reg  [12:0] ev = 13'h0;
  reg  [11:0] phase_idle_i = 12'h0;
  reg  [31:0] dat = 32'h0;
  wire        wr_en_i, power_up_done_i, mode_wake_done_i;
  wire        phase_order_fault_i, merged_voltage_crossing_i;
  wire [2:0]  current_crossing_i, voltage_crossing_i, crossing_timeout_i;
  wire [31:0] wr_data_i, status_ff_o;
  wire [11:0] per_phase_idle_indicator_o;
  integer     err_total = 0, tests_run = 0;
  assign {power_up_done_i, mode_wake_done_i, phase_order_fault_i,
    current_crossing_i, merged_voltage_crossing_i, voltage_crossing_i,
    crossing_timeout_i} = ev;
  event_flag_status_low dut_u (.*);
  host_model host_u (.clk_i(clk_i), .req_i(req), .d_i(dat),
    .st_i(status_ff_o), .we_o(wr_en_i), .wd_o(wr_data_i));
  initial forever #2.5 clk_i = ~clk_i;
  task gap;
    @(posedge clk_i) #1;
  endtask
  task pulse(input [12:0] m);
    @(posedge clk_i) ev <= m;
    @(posedge clk_i) ev <= 13'h0;
    gap;
  endtask
  // v lands on the same edge as the write strobe
  task wr(input [31:0] d, input [2:0] v);
    @(posedge clk_i) {req, dat} <= {1'b1, d};
    @(posedge clk_i) {req, ev} <= {1'b0, 7'h00, v, 3'h0};
    @(posedge clk_i) ev <= 13'h0;
    gap;
  endtask
  task t_init;
    pulse(13'h1000);
    `CHK("init", 32'h0001_0000, status_ff_o)
    wr(32'h0001_0000, 3'h0);
    `CHK("w1c", 32'h0, status_ff_o)
    pulse(13'h0800);
    `CHK("wake", 32'h0001_0000, status_ff_o)
  endtask
  task t_events;
    pulse(13'h07ff);
    `CHK("ev", 32'h0005_ffc0, status_ff_o)
    wr(32'h0, 3'h0);
    `CHK("w0", 32'h0005_ffc0, status_ff_o)
    wr(32'hffff_ffff, 3'h1);
    `CHK("win", 32'h0000_0200, status_ff_o)
  endtask
  task t_idle;
    @(posedge clk_i) phase_idle_i <= 12'h249;
    gap;
    `CHK("ind", 12'h249, per_phase_idle_indicator_o)
    gap;
    `CHK("idle", 32'h0000_0217, status_ff_o)
    wr(32'h0000_0217, 3'h0);
    `CHK("iclr", 32'h0, status_ff_o)
    `CHK("indclr", 12'h0, per_phase_idle_indicator_o)
  endtask
  task results;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    gap;
    `CHK("rst", 32'h0, status_ff_o)
    t_init;
    t_events;
    t_idle;
    results;
  end
endmodule
